/* File: display_serial_port.sv */
// Serial command port: shift register on the link clock, decode on the core clock
`timescale 1ns/100ps

// Functional notes
// R1 - Serial input shifts into a 16-bit register on each rising clock while select low.
// R2 - With select high, clock and data activity leave the shift register untouched.
// R3 - Serial output changes on the falling clock, showing the bit leaving the register.
// R4 - Each input bit appears on the output fifteen and a half cycles later, except bits replaced by a read load (R10).
// R5 - Select rising captures the last sixteen shifted bits as one command word.
// R6 - Serial output is always driven push-pull, never released, even with select high.
// R7 - Serial output is steady at every rising clock so the next party can sample.
// R8 - Host keeps serial input steady around each rising clock while select is low.
// R9 - Word goes MSB first: bit 15 read flag, 14..8 address, 7..0 data.
// R10 - A read loads the addressed contents into the low eight shift positions.
// R11 - Address zero is a no-op; it causes no action at all.
// R12 - Host lowers clock before select, and raises select with clock still high.
// R13 - The captured word crosses safely into the core clock before decoding.
// R14 - In a chain the host sends sixteen bits per device in one select period.
module display_serial_port
  import serial_port_pkg::*;
(
  // Core clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial link
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              din,
  output logic                   dout,
  // Decoded write command
  output logic                   cmd_wr,
  output logic      [ADDR_W-1:0] cmd_addr,
  output logic      [DATA_W-1:0] cmd_data
);

  // ------------------------------------------------------------
  // Link side reset
  // ------------------------------------------------------------
  // Leaves reset only after two sclk rises with rst low
  logic rst_link;

  level_sync #(.W(1)) u_rst_link (
    .clk (sclk),
    .d   (rst),
    .q   (rst_link)
  );

  // ------------------------------------------------------------
  // Link side shift register (rising sclk)
  // ------------------------------------------------------------
  logic [WORD_W-1:0] sr_q;
  logic [WORD_W-1:0] sr_d;
  logic [WORD_W-1:0] sr_base;
  logic              ack_q;
  logic              ack_d;
  logic              load_now;
  logic              armed_q;
  logic              rd_tgl_q;
  logic [DATA_W-1:0] rd_data_q;

  // Read data and its toggle change only in the select-high gap and are held static while select is low
  assign load_now = armed_q && !cs_n && (rd_tgl_q != ack_q);

  always_comb begin
    sr_base = sr_q;
    sr_d    = sr_q;
    ack_d   = ack_q;
    if (load_now) begin
      sr_base = {sr_q[WORD_W-1:DATA_W], rd_data_q}; // R10
    end
    if (!cs_n) begin
      sr_d  = {sr_base[WORD_W-2:0], din}; // R1 R8
      ack_d = armed_q ? rd_tgl_q : ack_q;
    end
  end

  always_ff @(posedge sclk) begin
    if (rst_link) begin
      sr_q  <= SR_RST;
      ack_q <= 1'b0;
    end else begin
      sr_q  <= sr_d; // R2
      ack_q <= ack_d;
    end
  end

  // ------------------------------------------------------------
  // Link side output (falling sclk)
  // ------------------------------------------------------------
  logic dout_q;
  logic dout_d;
  logic armed_d;

  always_comb begin
    dout_d  = sr_q[WORD_W-1]; // R3 R4
    armed_d = cs_n;           // R12
  end

  always_ff @(negedge sclk) begin
    if (rst_link) begin
      dout_q  <= DOUT_RST;
      armed_q <= 1'b0;
    end else begin
      dout_q  <= dout_d; // R7
      armed_q <= armed_d;
    end
  end

  // Push-pull pin, no enable
  assign dout = dout_q; // R6

  // ------------------------------------------------------------
  // Core side frame end detection
  // ------------------------------------------------------------
  logic cs_s;
  logic cs_prev_q;
  logic cs_prev_d;
  logic cs_rise;

  level_sync #(.W(1)) u_cs_sync (
    .clk (clk),
    .d   (cs_n),
    .q   (cs_s)
  );

  assign cs_rise = cs_s && !cs_prev_q;

  // ------------------------------------------------------------
  // Core side word latch and decode
  // ------------------------------------------------------------
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] word_d;
  logic              new_q;
  logic              new_d;
  logic              cmd_wr_q;
  logic              cmd_wr_d;
  logic [ADDR_W-1:0] cmd_addr_q;
  logic [ADDR_W-1:0] cmd_addr_d;
  logic [DATA_W-1:0] cmd_data_q;
  logic [DATA_W-1:0] cmd_data_d;
  logic              rd_tgl_d;
  logic [DATA_W-1:0] rd_data_d;
  logic [ADDR_W-1:0] word_addr;
  logic              word_rd;
  logic              word_live;
  logic [DATA_W-1:0] mem_q [REG_DEPTH];

  assign word_addr = word_q[ADDR_HI:ADDR_LO];
  assign word_rd   = (word_q[RW_BIT] == READ_CMD);
  assign word_live = new_q && (word_addr != NOOP_ADDR);

  always_comb begin
    cs_prev_d  = cs_s;
    word_d     = word_q;
    new_d      = 1'b0;
    cmd_wr_d   = 1'b0;
    cmd_addr_d = cmd_addr_q;
    cmd_data_d = cmd_data_q;
    rd_tgl_d   = rd_tgl_q;
    rd_data_d  = rd_data_q;
    if (cs_rise) begin
      // Shift register is idle while select is high
      word_d = sr_q; // R5 R13
      new_d  = 1'b1;
    end
    if (word_live && !word_rd) begin
      cmd_wr_d   = 1'b1; // R9
      cmd_addr_d = word_addr;
      cmd_data_d = word_q[DATA_HI:DATA_LO];
    end
    if (word_live && word_rd) begin
      rd_data_d = mem_q[word_addr]; // R10
      rd_tgl_d  = !rd_tgl_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_prev_q  <= 1'b1;
      word_q     <= SR_RST;
      new_q      <= 1'b0;
      cmd_wr_q   <= 1'b0;
      cmd_addr_q <= NOOP_ADDR;
      cmd_data_q <= DATA_RST;
      rd_tgl_q   <= 1'b0;
      rd_data_q  <= DATA_RST;
    end else begin
      cs_prev_q  <= cs_prev_d;
      word_q     <= word_d;
      new_q      <= new_d;
      cmd_wr_q   <= cmd_wr_d; // R11
      cmd_addr_q <= cmd_addr_d;
      cmd_data_q <= cmd_data_d;
      rd_tgl_q   <= rd_tgl_d;
      rd_data_q  <= rd_data_d;
    end
  end

  // ------------------------------------------------------------
  // Register image for read-back
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_q[i] <= DATA_RST;
      end
    end else if (word_live && !word_rd) begin
      mem_q[word_addr] <= word_q[DATA_HI:DATA_LO]; // R11
    end
  end

  assign cmd_wr   = cmd_wr_q;
  assign cmd_addr = cmd_addr_q;
  assign cmd_data = cmd_data_q;

  // ------------------------------------------------------------
  // Checks, link side
  // ------------------------------------------------------------
  a_shift_sample: assert property ( // R1
    @(posedge sclk) disable iff (rst_link)
    !cs_n |=> sr_q[0] == $past(din))
    else $error("Serial input bit not shifted in");

  a_shift_move: assert property ( // R1
    @(posedge sclk) disable iff (rst_link)
    (!cs_n && !load_now) |=> sr_q[WORD_W-1:1] == $past(sr_q[WORD_W-2:0]))
    else $error("Shift register did not advance");

  a_idle_hold: assert property ( // R2
    @(posedge sclk) disable iff (rst_link)
    cs_n |=> $stable(sr_q))
    else $error("Shift register moved with select high");

  a_dout_follow: assert property ( // R3
    @(negedge sclk) disable iff (rst_link)
    1'b1 |=> dout_q == $past(sr_q[WORD_W-1]))
    else $error("Serial output not the leaving bit");

  a_dout_steady: assert property ( // R7
    @(posedge sclk) disable iff (rst_link)
    1'b1 |=> dout_q == sr_q[WORD_W-1])
    else $error("Serial output not steady at rising clock");

  a_dout_delay: assert property ( // R4
    @(posedge sclk) disable iff (rst_link)
    (!cs_n && !load_now)[*8] ##1 (!cs_n && !load_now)[*8]
      |=> dout_q == $past(din, 16))
    else $error("Serial output delay is not fifteen and a half cycles");

  a_read_load: assert property ( // R10
    @(posedge sclk) disable iff (rst_link)
    load_now |=> sr_q[DATA_W:1] == $past(rd_data_q))
    else $error("Read data not loaded into low positions");

  a_load_once: assert property ( // R10
    @(posedge sclk) disable iff (rst_link)
    load_now |=> !load_now)
    else $error("Read data loaded more than once");

  // ------------------------------------------------------------
  // Checks, core side
  // ------------------------------------------------------------
  a_latch_word: assert property ( // R5
    @(posedge clk) disable iff (rst)
    cs_rise |=> new_q && word_q == $past(sr_q))
    else $error("Command word not latched at select rise");

  a_write_pulse: assert property ( // R9
    @(posedge clk) disable iff (rst)
    (new_q && !word_q[RW_BIT] && word_addr != NOOP_ADDR)
      |=> cmd_wr_q && cmd_addr_q == $past(word_addr)
          && cmd_data_q == $past(word_q[DATA_HI:DATA_LO]) ##1 !cmd_wr_q)
    else $error("Write command not issued as one pulse");

  a_cmd_hold: assert property ( // R11
    @(posedge clk) disable iff (rst)
    ($changed(cmd_addr_q) || $changed(cmd_data_q)) |-> cmd_wr_q)
    else $error("Command fields changed without a write");

  a_write_store: assert property ( // R9
    @(posedge clk) disable iff (rst)
    (word_live && !word_rd) |=> mem_q[$past(word_addr)] == $past(word_q[DATA_HI:DATA_LO]))
    else $error("Write did not update the register image");

  a_noop_quiet: assert property ( // R11
    @(posedge clk) disable iff (rst)
    (new_q && word_addr == NOOP_ADDR) |=> !cmd_wr_q && $stable(rd_tgl_q))
    else $error("No-op address caused an action");

  a_read_toggle: assert property ( // R10
    @(posedge clk) disable iff (rst)
    (new_q && word_rd && word_addr != NOOP_ADDR) |=> rd_tgl_q != $past(rd_tgl_q))
    else $error("Read command did not post data");

  a_read_data: assert property ( // R10
    @(posedge clk) disable iff (rst)
    (new_q && word_rd && word_addr != NOOP_ADDR) |=> rd_data_q == $past(mem_q[word_addr]))
    else $error("Read data is not the addressed register");

  a_sync_delay: assert property ( // R13
    @(posedge clk) disable iff (rst)
    $rose(cs_n) ##1 cs_n[*3] |-> ##[0:2] new_q)
    else $error("Frame end not seen within synchroniser delay");

endmodule

/* File: display_serial_port_test.sv */
// Self-checking bench for the display serial port
`timescale 1ns/100ps
module display_serial_port_test
  import serial_port_pkg::*;
;
  logic              clk, rst, sclk, cs_n, din, dout, cmd_wr;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic [31:0]       rx;
  int                n_fail, checks_done, n_wr, cycles;

  display_serial_port i_display_serial_port (.clk(clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data));
  host_model i_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulse counter and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cmd_wr === 1'b1) n_wr <= n_wr + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Frame plus count of write pulses it caused
  task automatic frame(input logic [31:0] w, input int n, input int slow, input int wr);
    int w0;
    w0 = n_wr;
    i_host_model.xfer(w, n, slow, rx);
    check_val(n_wr - w0, wr, "pulses");
  endtask

  task automatic t_reset();
    check_val({dout, cmd_wr, cmd_addr, cmd_data}, 0, "reset");
  endtask

  task automatic t_write();
    frame(32'h1234, 16, 0, 1);
    check_val(rx, 32'h0, "first out");
    check_val({cmd_addr, cmd_data}, 15'h1234, "write");
  endtask

  task automatic t_noop();
    frame(32'h00ab, 16, 0, 0);
    check_val(rx, 32'h1234, "echo");
    check_val({cmd_addr, cmd_data}, 15'h1234, "held");
  endtask

  task automatic t_read();
    frame(32'h9200, 16, 0, 0);
    check_val(rx, 32'h00ab, "echo");
    frame(32'h0000, 16, 0, 0);
    check_val(rx, 32'h9234, "read back");
    frame(32'h80ff, 16, 0, 0);
    check_val(rx, 32'h0, "echo zero");
    frame(32'h0000, 16, 0, 0);
    check_val(rx, 32'h80ff, "no-op read");
  endtask

  task automatic t_chain();
    frame(32'hc3a5_2a5c, 32, 20, 1);
    check_val(rx, 32'h0000_c3a5, "chain");
    check_val({cmd_addr, cmd_data}, 15'h2a5c, "last 16");
  endtask

  task automatic t_short();
    frame(32'h7e, 8, 0, 1);
    check_val(rx, 32'h2a, "short out");
    check_val({cmd_addr, cmd_data}, 15'h5c7e, "old fill");
  endtask

  task automatic t_ignore();
    i_host_model.idle(5);
    frame(32'h0000, 16, 0, 0);
    check_val(rx, 32'h5c7e, "kept");
    check_val(dout, 1'b0, "driven");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    i_host_model.idle(4);
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    // Link side leaves reset on sclk rises only
    i_host_model.idle(3);
    t_reset();
    t_write();
    t_noop();
    t_read();
    t_chain();
    t_short();
    t_ignore();
    final_report();
  end
endmodule

/* File: host_model.sv */
// Host model acting as master of the serial link
`timescale 1ns/100ps
module host_model (
  // Serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // Clock pulses with select high, data wiggling
  task automatic idle(input int n);
    repeat (n) begin
      #62.5;
      sclk = 1'b1;
      din  = ~din;
      #62.5;
      sclk = 1'b0;
    end
  endtask

  // One frame of n bits, MSB first; slow stretches each low phase
  task automatic xfer(input logic [31:0] w, input int n, input int slow,
                      output logic [31:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      #(62.5 + slow);
      rx   = {rx[30:0], dout};
      sclk = 1'b1;
      #62.5;
      if (i == 0) begin
        cs_n = 1'b1;
      end else begin
        sclk = 1'b0;
      end
    end
    #10;
    sclk = 1'b0;
    din  = ~din;
    #400;
  endtask
endmodule

/* File: level_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module level_sync
  import serial_port_pkg::*;
#(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Level in, level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q      <= q_d;
  end
endmodule

/* File: serial_port_pkg.sv */
// Constants shared by the display driver serial port
package serial_port_pkg;
  localparam int          WORD_W      = 16;
  localparam int          RW_BIT      = 15;
  localparam int          ADDR_HI     = 14;
  localparam int          ADDR_LO     = 8;
  localparam int          DATA_HI     = 7;
  localparam int          DATA_LO     = 0;
  localparam int          ADDR_W      = ADDR_HI - ADDR_LO + 1;
  localparam int          DATA_W      = DATA_HI - DATA_LO + 1;
  localparam int          REG_DEPTH   = 1 << ADDR_W;
  localparam int          SYNC_STAGES = 2;
  localparam logic [6:0]  NOOP_ADDR   = 7'h00;
  localparam logic [15:0] SR_RST      = 16'h0000;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic        DOUT_RST    = 1'b0;
  localparam logic        READ_CMD    = 1'b1;
  // Least time select must stay high so the core sees the frame end
  localparam int          CS_GAP_NS   = 250;
  localparam int          CLK_NS      = 50;
  localparam int          CS_GAP_CLKS = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage
